/* acc_pkg.sv */
package acc_pkg;
  // Register addresses on the special-function bus
  localparam logic [7:0] ADDR_INPUT_ENABLE = 8'hab;
  localparam logic [7:0] ADDR_CONV_CONTROL = 8'hac;
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'had;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hae;
  localparam logic [7:0] ADDR_CLOCK_DIVIDER = 8'haf;
  localparam logic [7:0] ADDR_SAMPLE_HOLD = 8'hef;
  // Calibration register in the external data space
  localparam logic [15:0] ADDR_CALIBRATION = 16'hffff;

  // Reset values
  localparam logic [7:0] RST_INPUT_ENABLE = 8'h00;
  localparam logic [7:0] RST_CONV_CONTROL = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;
  localparam logic [7:0] RST_CLOCK_DIVIDER = 8'h00;
  localparam logic [7:0] RST_SAMPLE_HOLD = 8'h00;
  localparam logic [7:0] RST_CALIBRATION = 8'h02;

  // Field positions
  localparam int CTRL_START_BIT = 7;
  localparam int CTRL_ALIGN_BIT = 6;
  localparam int CTRL_MODE_BIT = 5;
  localparam int CTRL_GATE_BIT = 4;
  localparam int CLK_REF_EN_BIT = 7;
  localparam int CLK_IN8_EN_BIT = 6;
  localparam int CAL_APPLY_BIT = 1;
  localparam int CAL_KICK_BIT = 0;

  // Widths and codes
  localparam int RESULT_W = 12;
  localparam int SRC_COUNT = 10;
  localparam int DIV_W = 5;
  localparam int CNT_W = 9;
  localparam int HALF_W = 7;
  localparam logic [3:0] LAST_PIN_CODE = 4'h8;
  localparam logic [3:0] REF_SOURCE = 4'h9;

  // Timing, in converter clocks unless noted
  localparam int DIV_FACTOR = 6;
  localparam int HALF_FACTOR = DIV_FACTOR / 2;
  localparam int TOTAL_DEF_CLOCKS = 16;
  localparam int TOTAL_SH_BASE = 19;
  localparam int CONVERT_CLOCKS = 12;
  localparam int FW_CONVERT_CLOCKS = 16;
  localparam int CAL_CLOCKS = 64;
  localparam int CAL_EXTRA_CLOCKS = 4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10,
    ST_CALIB = 2'b11
  } acc_state_t;

  // Select code to source index, anything above the last pin is the reference
  function automatic logic [3:0] acc_source_of(input logic [3:0] sel);
    return (sel <= LAST_PIN_CODE) ? sel : REF_SOURCE;
  endfunction

  // Hardware sampling length in converter clocks
  function automatic logic [CNT_W-1:0] acc_sample_len(input logic [7:0] sh);
    if (sh == 8'h00) begin
      return CNT_W'(TOTAL_DEF_CLOCKS - CONVERT_CLOCKS);
    end
    return CNT_W'(TOTAL_SH_BASE - CONVERT_CLOCKS) + CNT_W'(sh);
  endfunction
endpackage

/* acc_link_if.sv */
interface acc_link_if;
  import acc_pkg::*;
  logic [DIV_W-1:0] div_field;
  logic tick;
  logic conv_clk;
  logic load;
  logic align;
  logic [RESULT_W-1:0] result;
  logic [7:0] res_hi;
  logic [7:0] res_lo;
  modport divider(input div_field, output tick, output conv_clk);
  modport packer(input load, input align, input result, output res_hi, output res_lo);
  modport ctl(output div_field, output load, output align, output result,
    input tick, input conv_clk, input res_hi, input res_lo);
endinterface

/* acc_clk_div.sv */
module acc_clk_div
  import acc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  acc_link_if.divider lk
);
  logic [HALF_W-1:0] half_cnt;
  logic phase;
  logic [HALF_W-1:0] half_max;

  assign half_max = HALF_W'(HALF_FACTOR * (int'(lk.div_field) + 1) - 1); // [RULE_11]
  assign lk.tick = (half_cnt >= half_max) && !phase;
  assign lk.conv_clk = phase;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      half_cnt <= '0;
      phase <= 1'b0;
    end else if (half_cnt >= half_max) begin
      half_cnt <= '0;
      phase <= !phase;
    end else begin
      half_cnt <= half_cnt + 1'b1;
    end
  end

  // Helper: system clocks since the last tick
  logic [7:0] gap;
  logic seen;
  logic div_chg;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap <= '0;
      seen <= 1'b0;
      div_chg <= 1'b0;
    end else begin
      gap <= lk.tick ? 8'h00 : gap + 1'b1;
      seen <= seen | lk.tick;
      div_chg <= lk.tick ? 1'b0 : (div_chg | (lk.div_field != $past(lk.div_field)));
    end
  end

  chk_tick_period: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_11]
    lk.tick && seen && !div_chg && $stable(lk.div_field)
    |-> int'(gap) == DIV_FACTOR * (int'(lk.div_field) + 1) - 1)
    else $error("converter clock period wrong");
endmodule // acc_clk_div

/* acc_result_pack.sv */
module acc_result_pack
  import acc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  acc_link_if.packer lk
);
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lk.res_hi <= RST_RESULT;
      lk.res_lo <= RST_RESULT;
    end else if (lk.load && lk.align) begin
      lk.res_hi <= {4'h0, lk.result[11:8]}; // [RULE_04]
      lk.res_lo <= lk.result[7:0]; // [RULE_04]
    end else if (lk.load) begin
      lk.res_hi <= lk.result[11:4]; // [RULE_03]
      lk.res_lo <= {4'h0, lk.result[3:0]}; // [RULE_03]
    end
  end

  chk_align_left: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_03]
    lk.load && !lk.align |=> lk.res_hi == $past(lk.result[11:4])
      && lk.res_lo == {4'h0, $past(lk.result[3:0])})
    else $error("left aligned result wrong");
  chk_align_right: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_04]
    lk.load && lk.align |=> lk.res_hi == {4'h0, $past(lk.result[11:8])}
      && lk.res_lo == $past(lk.result[7:0]))
    else $error("right aligned result wrong");
  chk_result_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_19]
    !lk.load |=> $stable(lk.res_hi) && $stable(lk.res_lo))
    else $error("result changed without a completion");
endmodule // acc_result_pack

/* acc_conversion_control.sv */
// How it works
// (RULE_01) Twelve-bit result; ten sources: pins 0 to 8 and bandgap reference.
// (RULE_02) Writing start launches one single-shot conversion of the selected input.
// (RULE_03) Alignment 0: result 11:4 in high byte, 3:0 low nibble of low.
// (RULE_04) Alignment 1: result 11:8 low nibble of high, 7:0 in low byte.
// (RULE_05) Sample mode 0 times sampling in hardware, 1 leaves it to firmware.
// (RULE_06) Firmware mode samples while the sample gate bit is 1.
// (RULE_07) Select codes 0 to 8 pick pins, other codes pick the reference.
// (RULE_08) Input enable bits 0 to 7 enable the matching pins.
// (RULE_09) Clock register bit enables pin 8.
// (RULE_10) Clock register bit enables the bandgap reference source.
// (RULE_11) Converter clock is system clock over six times divider plus one.
// (RULE_12) Hardware mode, zero hold length: sixteen converter clocks per conversion.
// (RULE_13) Hardware mode, nonzero hold length: nineteen clocks plus the length.
// (RULE_14) Firmware mode: sixteen clocks plus the firmware sampling interval.
// (RULE_15) Hold length matters only in hardware sampling mode.
// (RULE_16) Software sets calibration kick, then waits for it to read 0.
// (RULE_17) Hardware clears the calibration kick when calibration is done.
// (RULE_18) Calibration apply with the source enabled lengthens the conversion.
// (RULE_19) Completion clears start and loads both result bytes together.
// (RULE_20) Start or calibration requests while busy are ignored.
module acc_conversion_control
  import acc_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [15:0] xdata_addr_i,
  input wire logic xdata_wr_i,
  input wire logic xdata_rd_i,
  input wire logic [7:0] xdata_wdata_i,
  output logic [7:0] xdata_rdata_o,
  input wire logic [RESULT_W-1:0] core_result_i,
  output logic conv_clk_o,
  output logic [SRC_COUNT-1:0] source_enable_o,
  output logic [3:0] input_select_o,
  output logic sample_o,
  output logic convert_o,
  output logic calibrate_o,
  output logic use_calibration_o,
  output logic busy_o
);
  acc_link_if lk ();

  logic [7:0] input_enable;
  logic [7:0] conv_control;
  logic [7:0] clock_divider;
  logic [7:0] sample_hold;
  logic [7:0] cal_control;

  acc_state_t state;
  acc_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic fw_mode;
  logic gate_seen;
  logic cal_path;
  logic [7:0] sh_lat;

  logic wr_ctrl;
  logic wr_cal;
  logic launch_conv;
  logic launch_cal;
  logic conv_done;
  logic cal_done;
  logic [3:0] src_now;
  logic [SRC_COUNT-1:0] src_enables;

  acc_clk_div u_div (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .lk(lk.divider)
  );

  acc_result_pack u_pack (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .lk(lk.packer)
  );

  // Source enables: pins 0..7, pin 8, reference
  assign src_enables = {clock_divider[CLK_REF_EN_BIT], // [RULE_10]
    clock_divider[CLK_IN8_EN_BIT], // [RULE_09]
    input_enable}; // [RULE_08]
  assign source_enable_o = src_enables;
  assign src_now = acc_source_of(sfr_wdata_i[3:0]); // [RULE_07]

  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == ADDR_CONV_CONTROL);
  assign wr_cal = xdata_wr_i && (xdata_addr_i == ADDR_CALIBRATION);
  assign busy_o = (state != ST_IDLE);
  assign launch_conv = wr_ctrl && sfr_wdata_i[CTRL_START_BIT] && !busy_o; // [RULE_02] [RULE_20]
  assign launch_cal = wr_cal && xdata_wdata_i[CAL_KICK_BIT] && !busy_o
    && !launch_conv; // [RULE_20]
  assign conv_done = (state == ST_CONVERT) && lk.tick && (cnt == CNT_W'(1));
  assign cal_done = (state == ST_CALIB) && lk.tick && (cnt == CNT_W'(1));

  assign lk.div_field = clock_divider[DIV_W-1:0]; // [RULE_11]
  assign lk.load = conv_done; // [RULE_19]
  assign lk.align = conv_control[CTRL_ALIGN_BIT];
  assign lk.result = core_result_i; // [RULE_01]
  assign conv_clk_o = lk.conv_clk;

  // Core strobes decoded from state flops
  assign sample_o = (state == ST_SAMPLE)
    && (fw_mode ? conv_control[CTRL_GATE_BIT] : 1'b1); // [RULE_05] [RULE_06]
  assign convert_o = (state == ST_CONVERT);
  assign calibrate_o = (state == ST_CALIB);
  assign use_calibration_o = cal_path && (state == ST_SAMPLE || state == ST_CONVERT);

  // Input enable register
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      input_enable <= RST_INPUT_ENABLE;
    end else if (sfr_wr_i && sfr_addr_i == ADDR_INPUT_ENABLE) begin
      input_enable <= sfr_wdata_i; // [RULE_08]
    end
  end

  // Conversion control; start is held while busy and cleared on completion
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      conv_control <= RST_CONV_CONTROL;
    end else begin
      if (wr_ctrl) begin
        conv_control[CTRL_ALIGN_BIT:0] <= sfr_wdata_i[CTRL_ALIGN_BIT:0];
      end
      if (launch_conv) begin
        conv_control[CTRL_START_BIT] <= 1'b1; // [RULE_02]
      end else if (conv_done) begin
        conv_control[CTRL_START_BIT] <= 1'b0; // [RULE_19]
      end
    end
  end

  // Clock select register, bit 5 reserved and read as zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      clock_divider <= RST_CLOCK_DIVIDER;
    end else if (sfr_wr_i && sfr_addr_i == ADDR_CLOCK_DIVIDER) begin
      clock_divider <= {sfr_wdata_i[7:6], 1'b0, sfr_wdata_i[DIV_W-1:0]}; // [RULE_09] [RULE_10]
    end
  end

  // Sample and hold length
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sample_hold <= RST_SAMPLE_HOLD;
    end else if (sfr_wr_i && sfr_addr_i == ADDR_SAMPLE_HOLD) begin
      sample_hold <= sfr_wdata_i;
    end
  end

  // Calibration register; kick held while calibrating, cleared at the end
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_control <= RST_CALIBRATION;
    end else begin
      if (wr_cal) begin
        cal_control[CAL_APPLY_BIT] <= xdata_wdata_i[CAL_APPLY_BIT];
      end
      if (launch_cal) begin
        cal_control[CAL_KICK_BIT] <= 1'b1;
      end else if (cal_done) begin
        cal_control[CAL_KICK_BIT] <= 1'b0; // [RULE_17]
      end
    end
  end

  // Per-conversion settings caught at launch
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fw_mode <= 1'b0;
      cal_path <= 1'b0;
      sh_lat <= 8'h00;
      input_select_o <= 4'h0;
    end else if (launch_conv) begin
      fw_mode <= sfr_wdata_i[CTRL_MODE_BIT]; // [RULE_05]
      cal_path <= cal_control[CAL_APPLY_BIT] && src_enables[src_now]; // [RULE_18]
      sh_lat <= sample_hold; // [RULE_15]
      input_select_o <= src_now; // [RULE_07]
    end
  end

  // Firmware gate must open before its closing ends sampling
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_seen <= 1'b0;
    end else if (state != ST_SAMPLE) begin
      gate_seen <= 1'b0;
    end else if (conv_control[CTRL_GATE_BIT]) begin
      gate_seen <= 1'b1; // [RULE_06]
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      ST_IDLE: begin
        if (launch_conv) begin
          next_state = ST_SAMPLE;
          next_cnt = acc_sample_len(sample_hold); // [RULE_12] [RULE_13]
        end else if (launch_cal) begin
          next_state = ST_CALIB;
          next_cnt = CNT_W'(CAL_CLOCKS);
        end
      end
      ST_SAMPLE: begin
        if (fw_mode) begin
          if (gate_seen && !conv_control[CTRL_GATE_BIT]) begin
            next_state = ST_CONVERT; // [RULE_14]
            next_cnt = CNT_W'(FW_CONVERT_CLOCKS) + (cal_path ? CNT_W'(CAL_EXTRA_CLOCKS) : '0);
          end
        end else if (lk.tick) begin
          if (cnt == CNT_W'(1)) begin
            next_state = ST_CONVERT;
            next_cnt = CNT_W'(CONVERT_CLOCKS) + (cal_path ? CNT_W'(CAL_EXTRA_CLOCKS) : '0); // [RULE_18]
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
      end
      ST_CONVERT, ST_CALIB: begin
        if (lk.tick) begin
          if (cnt == CNT_W'(1)) begin
            next_state = ST_IDLE;
            next_cnt = '0;
          end else begin
            next_cnt = cnt - 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Registered read data, unmapped addresses read zero
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      unique case (sfr_addr_i)
        ADDR_INPUT_ENABLE: sfr_rdata_o <= input_enable;
        ADDR_CONV_CONTROL: sfr_rdata_o <= conv_control;
        ADDR_RESULT_HIGH: sfr_rdata_o <= lk.res_hi;
        ADDR_RESULT_LOW: sfr_rdata_o <= lk.res_lo;
        ADDR_CLOCK_DIVIDER: sfr_rdata_o <= clock_divider;
        ADDR_SAMPLE_HOLD: sfr_rdata_o <= sample_hold;
        default: sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xdata_rdata_o <= 8'h00;
    end else if (xdata_rd_i) begin
      xdata_rdata_o <= (xdata_addr_i == ADDR_CALIBRATION) ? cal_control : 8'h00; // [RULE_17]
    end
  end

  // Helper: converter clocks spent in one conversion
  logic [CNT_W:0] tick_total;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_total <= '0;
    end else if (launch_conv) begin
      tick_total <= '0;
    end else if (lk.tick && (state == ST_SAMPLE || state == ST_CONVERT)) begin
      tick_total <= tick_total + 1'b1;
    end
  end

  chk_launch_conv: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_02]
    launch_conv |=> state == ST_SAMPLE && conv_control[CTRL_START_BIT])
    else $error("start did not launch a conversion");
  chk_busy_ignore: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_20]
    busy_o && wr_ctrl && !conv_done |=> $stable(input_select_o) && $stable(sh_lat))
    else $error("request taken while busy");
  chk_start_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_19]
    conv_done |=> !conv_control[CTRL_START_BIT] && state == ST_IDLE)
    else $error("start not cleared on completion");
  chk_cal_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_17]
    cal_done |=> !cal_control[CAL_KICK_BIT] && state == ST_IDLE)
    else $error("calibration kick not cleared");
  chk_fw_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_06]
    state == ST_SAMPLE && fw_mode |-> sample_o == conv_control[CTRL_GATE_BIT])
    else $error("sampling does not follow the gate");
  chk_hw_default: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_12]
    conv_done && !fw_mode && !cal_path && sh_lat == 8'h00
    |-> int'(tick_total) + 1 == TOTAL_DEF_CLOCKS)
    else $error("default conversion length wrong");
  chk_hw_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_13]
    conv_done && !fw_mode && !cal_path && sh_lat != 8'h00
    |-> int'(tick_total) + 1 == TOTAL_SH_BASE + int'(sh_lat))
    else $error("programmed conversion length wrong");
  chk_sel_route: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_07]
    launch_conv |=> input_select_o == (($past(sfr_wdata_i[3:0]) <= LAST_PIN_CODE)
      ? $past(sfr_wdata_i[3:0]) : REF_SOURCE))
    else $error("input routing wrong");
  chk_cal_len: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [RULE_18]
    state == ST_SAMPLE && !fw_mode && next_state == ST_CONVERT
    |=> cnt == CNT_W'(CONVERT_CLOCKS) + (cal_path ? CNT_W'(CAL_EXTRA_CLOCKS) : '0))
    else $error("calibrated conversion not lengthened");
endmodule // acc_conversion_control

/* acc_core_model.sv */
module acc_core_model
  import acc_pkg::*;
(
  input wire logic convert_i,
  input wire logic [3:0] source_i,
  output logic [RESULT_W-1:0] result_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Level depends on the routed source; inverted outside the conversion phase
  always_comb begin
    result_o = {source_i, 8'h3c} ^ 12'h5a1;
    if (!convert_i) begin
      result_o = ~result_o;
    end
  end
endmodule // acc_core_model

/* acc_conversion_control_tb_top.sv */
module acc_conversion_control_tb_top;
  import acc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic [7:0] sfr_rdata_o;
  logic [15:0] xdata_addr_i = 16'h0000;
  logic xdata_wr_i = 1'b0;
  logic xdata_rd_i = 1'b0;
  logic [7:0] xdata_wdata_i = 8'h00;
  logic [7:0] xdata_rdata_o;
  logic [RESULT_W-1:0] core_result_i;
  logic conv_clk_o;
  logic [SRC_COUNT-1:0] source_enable_o;
  logic [3:0] input_select_o;
  logic sample_o;
  logic convert_o;
  logic calibrate_o;
  logic use_calibration_o;
  logic busy_o;
  int n_mismatch = 0;
  int n_tests = 0;

  acc_conversion_control dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .xdata_addr_i(xdata_addr_i), .xdata_wr_i(xdata_wr_i),
    .xdata_rd_i(xdata_rd_i), .xdata_wdata_i(xdata_wdata_i), .xdata_rdata_o(xdata_rdata_o),
    .core_result_i(core_result_i), .conv_clk_o(conv_clk_o),
    .source_enable_o(source_enable_o), .input_select_o(input_select_o), .sample_o(sample_o),
    .convert_o(convert_o), .calibrate_o(calibrate_o),
    .use_calibration_o(use_calibration_o), .busy_o(busy_o));

  acc_core_model core (.convert_i(convert_o), .source_i(input_select_o),
    .result_o(core_result_i));

  always #12.5 clk_i = ~clk_i;

  task automatic end_sim();
    $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus cycle; reads return the registered data one cycle later
  task automatic acc(input bit xd, input bit rd, input logic [15:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_i);
    #1;
    if (xd) begin
      xdata_addr_i = a;
      xdata_wdata_i = d;
      xdata_wr_i = !rd;
      xdata_rd_i = rd;
    end else begin
      sfr_addr_i = a[7:0];
      sfr_wdata_i = d;
      sfr_wr_i = !rd;
      sfr_rd_i = rd;
    end
    @(posedge clk_i);
    #1;
    {xdata_wr_i, xdata_rd_i, sfr_wr_i, sfr_rd_i} = 4'h0;
    q = xd ? xdata_rdata_o : sfr_rdata_o;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b0, 1'b0, {8'h00, a}, d, q);
  endtask

  task automatic rd_chk(input bit xd, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(xd, 1'b1, a, 8'h00, q);
    check({8'h00, q}, {8'h00, e});
  endtask

  // Busy length in system clocks against a tick count and converter period
  task automatic run_chk(input int t, input int p);
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check(16'((n >= (t - 1) * p && n <= (t + 1) * p + 2) ? t : n), 16'(t));
  endtask

  // Rising edges of the converter clock over four nominal periods
  task automatic per_chk(input int p);
    int rises;
    logic last;
    rises = 0;
    last = conv_clk_o;
    repeat (4 * p) begin
      @(posedge clk_i);
      #1;
      rises += (conv_clk_o === 1'b1 && last === 1'b0) ? 1 : 0;
      last = conv_clk_o;
    end
    check(16'(rises), 16'h0004);
  endtask

  task automatic res_chk(input logic [3:0] sel, input bit al);
    logic [11:0] r;
    r = {((sel <= 4'h8) ? sel : 4'h9), 8'h3c} ^ 12'h5a1;
    rd_chk(1'b0, 16'h00ad, al ? {4'h0, r[11:8]} : r[11:4]);
    rd_chk(1'b0, 16'h00ae, al ? r[7:0] : {4'h0, r[3:0]});
  endtask

  task automatic t_reset();
    logic [7:0] adr [7] = '{8'hab, 8'hac, 8'had, 8'hae, 8'haf, 8'hef, 8'hb0};
    wr(8'had, 8'hff);
    for (int i = 0; i < 7; i++) begin
      rd_chk(1'b0, {8'h00, adr[i]}, 8'h00);
    end
    rd_chk(1'b1, 16'hffff, 8'h02);
    rd_chk(1'b1, 16'hfffe, 8'h00);
    check({15'h0000, busy_o}, 16'h0000);
  endtask

  task automatic t_enables();
    wr(8'hab, 8'h5a);
    wr(8'haf, 8'hff);
    rd_chk(1'b0, 16'h00af, 8'hdf);
    check({6'h00, source_enable_o}, {6'h00, 2'b11, 8'h5a});
    wr(8'hab, 8'ha5);
    wr(8'haf, 8'h00);
    check({6'h00, source_enable_o}, {6'h00, 2'b00, 8'ha5});
  endtask

  task automatic t_select();
    logic [7:0] en;
    int t;
    // Pin enables left by t_enables; apply bit still at its reset value
    en = 8'ha5;
    for (int s = 0; s < 16; s++) begin
      t = TOTAL_DEF_CLOCKS + ((s < 8 && en[s]) ? CAL_EXTRA_CLOCKS : 0);
      wr(8'hac, 8'h80 | 8'(s));
      check({12'h000, input_select_o}, (s <= 8) ? 16'(s) : 16'h0009);
      if (s == 0) begin
        wr(8'hac, 8'h80);
      end
      run_chk(t, 6);
      res_chk(4'(s), 1'b0);
      rd_chk(1'b0, 16'h00ac, 8'(s));
    end
    repeat (10) @(posedge clk_i);
    check({15'h0000, busy_o}, 16'h0000);
  endtask

  task automatic t_hold();
    wr(8'haf, 8'h01);
    wr(8'hef, 8'h03);
    wr(8'hac, 8'hc1);
    run_chk(22, 12);
    res_chk(4'h1, 1'b1);
    per_chk(12);
    wr(8'haf, 8'h00);
  endtask

  task automatic t_firmware();
    wr(8'hac, 8'ha4);
    repeat (5) @(posedge clk_i);
    check({15'h0000, sample_o}, 16'h0000);
    wr(8'hac, 8'hb4);
    check({15'h0000, sample_o}, 16'h0001);
    repeat (20) @(posedge clk_i);
    wr(8'hac, 8'ha4);
    run_chk(16, 6);
    res_chk(4'h4, 1'b0);
  endtask

  task automatic t_calibration();
    logic [7:0] q;
    int n;
    acc(1'b1, 1'b0, 16'hffff, 8'h03, q);
    check({15'h0000, calibrate_o}, 16'h0001);
    wr(8'hac, 8'h80);
    n = 0;
    q = 8'h01;
    while (q[0] !== 1'b0 && n < 300) begin
      acc(1'b1, 1'b1, 16'hffff, 8'h00, q);
      n++;
    end
    check({8'h00, q}, 16'h0002);
    repeat (3) @(posedge clk_i);
    check({15'h0000, busy_o}, 16'h0000);
    wr(8'hef, 8'h00);
    wr(8'hac, 8'h80);
    check({15'h0000, use_calibration_o}, 16'h0001);
    run_chk(20, 6);
    res_chk(4'h0, 1'b0);
  endtask

  initial begin
    #(25 * 20000);
    n_mismatch++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    t_reset();
    t_enables();
    t_select();
    t_hold();
    t_firmware();
    t_calibration();
    end_sim();
  end
endmodule // acc_conversion_control_tb_top
